// file: gauge_register_map_and_led_display_tb.sv
/*
  Self-checking bench: host model on the command link, register model
  in integers, straps and gauge pulses driven here.
  Assumes a short time base tick so display and delay counts stay brief.
*/
`timescale 1ns/1ps
module gauge_register_map_and_led_display_tb;
  import gm_pkg::*;
  localparam int TK = 4;
  logic       ref_clk, rst_n, cmd_strobe, read_valid, chg_tick, dsg_tick, sd_tick;
  logic       valid_charge, rate_half, rate_2c, led_show_hi, led_show_lo;
  logic [7:0] command_byte, write_data, read_data, vsb_sample, rv, acc;
  logic [3:0] temp_code;
  logic [5:0] strap_pd_pins, strap_pu_pins;
  logic [4:0] led_drive_outputs;
  int         err_count, num_checks;
  int         mdl [128];
  logic [6:0] ra [8] = '{A_NOMINAL_CHARGE_HIGH, A_NOMINAL_CHARGE_LOW, A_LMD, A_VTS, A_CPI, A_PPD, A_PPU, 7'h0A};
  logic [6:0] rs [4] = '{A_NOMINAL_CHARGE_HIGH, A_NOMINAL_CHARGE_LOW, A_LMD, A_CPI};
  logic [3:0] pv;
  // gauge pulse inputs as one vector so a single task can strobe any of them
  assign {valid_charge, sd_tick, dsg_tick, chg_tick} = pv;

  gm_gauge_regs #(.TICK_CYCLES(TK)) i_gm_gauge_regs (
    .ref_clk(ref_clk), .rst_n(rst_n), .command_byte(command_byte),
    .cmd_strobe(cmd_strobe), .write_data(write_data), .read_data(read_data),
    .read_valid(read_valid), .chg_tick(chg_tick), .dsg_tick(dsg_tick),
    .sd_tick(sd_tick), .valid_charge(valid_charge), .rate_half(rate_half),
    .rate_2c(rate_2c), .temp_code(temp_code), .vsb_sample(vsb_sample),
    .led_show_hi(led_show_hi), .led_show_lo(led_show_lo),
    .strap_pd_pins(strap_pd_pins), .strap_pu_pins(strap_pu_pins),
    .led_drive_outputs(led_drive_outputs));
  gm_host_model i_gm_host_model (
    .ref_clk(ref_clk), .read_data(read_data), .read_valid(read_valid),
    .command_byte(command_byte), .cmd_strobe(cmd_strobe), .write_data(write_data));

  // 20 MHz reference
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // read one register and compare the masked bits with the model
  task automatic rchk(input logic [6:0] a, input logic [7:0] m);
    i_gm_host_model.rd(a, rv);
    chk(rv & m, 8'(mdl[a]) & m);
  endtask
  // pulses on bit b of pv: 0 charge, 1 discharge, 2 self-discharge, 3 valid charge
  task automatic pulse(input int b, input int n);
    repeat (n) begin
      @(posedge ref_clk) pv[b] <= 1'b1;
      @(posedge ref_clk) pv[b] <= 1'b0;
    end
  endtask
  // segments over a frame and a half: only whole banks may show
  task automatic watch_leds();
    acc = 8'h00;
    repeat (30 * TK) begin
      @(posedge ref_clk) #1;
      acc = acc | 8'(led_drive_outputs);
      chk(8'(led_drive_outputs inside {5'h00, BANK_A, BANK_B}), 8'h01);
    end
  endtask
  task automatic summarize();
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard, far beyond the longest delay in the sequence
  initial begin
    repeat (40000) @(posedge ref_clk);
    err_count++;
    summarize();
  end

  initial begin
    void'($urandom(37185));
    {rst_n, rate_half, rate_2c} = 3'h0;
    pv = 4'h0;
    {led_show_hi, led_show_lo} = 2'b00;
    err_count = 0;
    num_checks = 0;
    temp_code = 4'h6; // warm, no cold correction
    vsb_sample = 8'h80 | 8'($urandom); // kept above any threshold written below
    strap_pd_pins = 6'($urandom);
    strap_pu_pins = 6'($urandom) | 6'h10; // pin five high
    foreach (mdl[i]) mdl[i] = 0;
    mdl[A_LMD] = PFC_CNT;
    mdl[A_VTS] = VTS_RST;
    mdl[A_PPD] = strap_pd_pins;
    mdl[A_PPU] = strap_pu_pins;
    mdl[A_FLG1] = 8'h50;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    foreach (ra[i]) rchk(ra[i], 8'hFF);
    rchk(A_FLG1, 8'h50);
    // writable bytes keep data; read-only byte and hole ignore it
    mdl[A_BID] = $urandom & 8'hFF;
    mdl[A_VTS] = $urandom & 8'h7F;
    i_gm_host_model.wr(A_BID, 8'(mdl[A_BID]));
    i_gm_host_model.wr(A_VTS, 8'(mdl[A_VTS]));
    i_gm_host_model.wr(A_CPI, 8'hA5);
    i_gm_host_model.wr(7'h0A, 8'h5A);
    foreach (ra[i]) rchk(ra[i], 8'hFF);
    rchk(A_BID, 8'hFF);
    // high byte write, three discharge counts, self-discharge off,
    // seventeen charge ticks of which the sixteenth is lost
    i_gm_host_model.wr(A_NOMINAL_CHARGE_HIGH, 8'h40);
    pulse(1, 3);
    pulse(2, 2);
    pulse(0, 17);
    mdl[A_NOMINAL_CHARGE_HIGH] = 8'h40;
    mdl[A_NOMINAL_CHARGE_LOW] = 8'h0D;
    rchk(A_NOMINAL_CHARGE_HIGH, 8'hFF);
    rchk(A_NOMINAL_CHARGE_LOW, 8'hFF);
    // charge events below the 94 percent level, then past saturation
    pulse(3, 64);
    mdl[A_CPI] = CPI_STL;
    rchk(A_CPI, 8'hFF);
    rchk(A_FLG1, 8'h10);
    pulse(3, 236);
    mdl[A_CPI] = CPI_MAX;
    rchk(A_CPI, 8'hFF);
    // just under learned capacity: both banks show; pin high blanks the bar
    i_gm_host_model.wr(A_NOMINAL_CHARGE_HIGH, 8'h7F);
    @(posedge ref_clk) led_show_lo <= 1'b1;
    repeat (4) @(posedge ref_clk);
    led_show_lo <= 1'b0;
    watch_leds();
    chk(acc, 8'h1F);
    @(posedge ref_clk) led_show_hi <= 1'b1;
    repeat (4) @(posedge ref_clk);
    watch_leds();
    chk(acc, 8'h00);
    // rate codes, then overload held after the 2C level drops
    @(posedge ref_clk) rate_half <= 1'b1;
    mdl[A_FLG2] = 8'h10;
    rchk(A_FLG2, 8'h71);
    @(posedge ref_clk) rate_2c <= 1'b1;
    mdl[A_FLG2] = 8'h21;
    rchk(A_FLG2, 8'h71);
    @(posedge ref_clk) {rate_half, rate_2c} <= 2'b00;
    mdl[A_FLG2] = 8'h01;
    repeat (900 * TK) @(posedge ref_clk);
    rchk(A_FLG2, 8'h71);
    repeat (200 * TK) @(posedge ref_clk);
    mdl[A_FLG2] = 8'h00;
    rchk(A_FLG2, 8'h71);
    repeat (1200 * TK) @(posedge ref_clk);
    mdl[A_VSB] = vsb_sample;
    rchk(A_VSB, 8'hFF);
    // learned capacity write, then arm and fire the reset byte
    mdl[A_LMD] = 8'h80 | 8'($urandom);
    i_gm_host_model.wr(A_LMD, 8'(mdl[A_LMD]));
    rchk(A_LMD, 8'hFF);
    i_gm_host_model.wr(A_RST, RST_ARM);
    i_gm_host_model.wr(A_RST, RST_GO);
    repeat (3) @(posedge ref_clk);
    mdl[A_LMD] = PFC_CNT;
    mdl[A_NOMINAL_CHARGE_HIGH] = 0;
    mdl[A_NOMINAL_CHARGE_LOW] = 0;
    mdl[A_CPI] = 0;
    mdl[A_FLG1] = 8'h50;
    foreach (rs[i]) rchk(rs[i], 8'hFF);
    rchk(A_FLG1, 8'h50);
    summarize();
  end
endmodule

// file: gm_gauge_regs.sv
/*
  Register bank, learning logic and five-segment LED bar of a
  single-cell capacity monitor. Assumes a serial front end that
  delivers a whole command byte plus data, and gauge front-end
  pulses and levels on the same clock.
*/
// Overview of operation
// - nominal count: writable high byte, counts up on charge, down on discharge
// - identifier byte is free host storage, no reset, no effect
// - learned capacity byte is taken from a measured full discharge
// - rate code in bits 6..4: below 0.5C, up to 2C, 2C and above
// - overload follows 2C, clears 0.5 s later, stops empty sampling
// - two six-bit read-only strap maps, pull-down and pull-up
// - charge event counter saturates at 255
// - above 94 percent, count one charge until level drops below
// - stale flag set when event counter reaches 64
// - learned capacity update clears counter and stale flag
// - learn only from full to first empty, no charge, warm, low self-discharge
// - voltage byte refreshed once per second
// - first empty threshold from setting byte, final 50 mV lower, default A2h
// - compensated capacity leaves nominal and learned counts alone
// - energy value from voltage and compensated capacity
// - writing 80h over 00h to reset register resets the gauge
// - reset loads learned capacity, zeroes counts, sets stale and replaced
// - strap pin five high stops self-discharge decrements
// - each of five segments is 20 percent of learned capacity
// - display pin high off, float on charge, low for four seconds
// - banks 1,3,5 and 2,4 alternate near 100 Hz, 30 percent each
// - segment one blinks 4 Hz on first empty, all off on final empty
// - address is low seven command bits, bad writes ignored
`timescale 1ns/1ps
module gm_gauge_regs
  import gm_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] command_byte,
  input  wire logic       cmd_strobe,
  input  wire logic [7:0] write_data,
  output logic      [7:0] read_data,
  output logic            read_valid,
  input  wire logic       chg_tick,
  input  wire logic       dsg_tick,
  input  wire logic       sd_tick,
  input  wire logic       valid_charge,
  input  wire logic       rate_half,
  input  wire logic       rate_2c,
  input  wire logic [3:0] temp_code,
  input  wire logic [7:0] vsb_sample,
  input  wire logic       led_show_hi,
  input  wire logic       led_show_lo,
  input  wire logic [5:0] strap_pd_pins,
  input  wire logic [5:0] strap_pu_pins,
  output logic      [4:0] led_drive_outputs
);
  logic [15:0] nac_q, cac_q, sae_q, dacc_q;
  logic [7:0]  lmd_q, bid_q, vts_q, vsb_q, cpi_q, rreg_q;
  logic [12:0] self_discharge_counter_q;
  logic [13:0] pre_q, mux_q, blk_q, vct_q, oct_q, sct_q;
  logic [5:0]  pd1_q, pd2_q, pu1_q, pu2_q;
  logic [1:0]  dh_q, dl_q;
  logic [2:0]  rate_q;
  logic [3:0]  eff_q;
  logic [4:0]  lit, led_q;
  logic        ci_q, brp_q, vdq_q, e1_q, ef_q, overload_flag_q, lock_q;
  logic        swr_q, vch_q, dlp_q, rv_q, vok_q;
  logic [7:0]  rd_d;
  gm_led_show_pin_t    led_show_pin_q;
  logic        tick, wr, chg_evt, chg_cnt, sd_en, full94, below94;
  logic        e1_hit, ef_hit, lmd_upd, cpi_inc, show;
  logic [6:0]  addr;

  // write decode used by every writable register
  function automatic logic hit(input logic [6:0] a, input logic [6:0] t,
                               input logic w);
    return w && (a == t);
  endfunction

  assign addr = command_byte[6:0];
  assign wr = cmd_strobe && command_byte[7];
  assign chg_evt = valid_charge && !vch_q;
  assign chg_cnt = chg_tick && (eff_q != EFF_LAST); // efficiency loss
  assign sd_en = sd_tick && !pu2_q[STRAP_PIN_FIVE];
  assign full94 = ({8'h00, nac_q} * TH_DEN) > ({8'h00, lmd_q, 8'h00} * TH_NUM);
  assign below94 = ({8'h00, nac_q} * TH_DEN) < ({8'h00, lmd_q, 8'h00} * TH_NUM);
  // overload blocks empty-voltage sampling; no verdict before the first
  // voltage sample, else the zero reset reading trips both flags
  assign e1_hit = vok_q && !overload_flag_q && (vsb_q < vts_q);
  assign ef_hit = vok_q && !overload_flag_q && (({1'b0, vsb_q} + FINAL_EMPTY_FLAG_CODE) < {1'b0, vts_q});
  assign lmd_upd = e1_hit && !e1_q && vdq_q && (temp_code >= COLD_TMP)
                   && (self_discharge_counter_q < SELF_DISCHARGE_COUNTER_LIM);
  assign cpi_inc = chg_evt && !lock_q && (cpi_q != CPI_MAX);
  assign tick = (pre_q == 14'(TICK_CYCLES - 1));

  // common time base prescaler
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 14'h0000;
    end else begin
      pre_q <= tick ? 14'h0000 : pre_q + 14'h0001;
    end
  end

  // tick-driven display and sample counters
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mux_q <= 14'h0000;
      blk_q <= 14'h0000;
      vct_q <= 14'h0000;
      vsb_q <= 8'h00;
      vok_q <= 1'b0;
    end else if (tick) begin
      mux_q <= (mux_q == MUX_T - 14'h0001) ? 14'h0000 : mux_q + 14'h0001;
      blk_q <= (blk_q == BLINK_T - 14'h0001) ? 14'h0000 : blk_q + 14'h0001;
      vct_q <= (vct_q == VSB_T - 14'h0001) ? 14'h0000 : vct_q + 14'h0001;
      if (vct_q == VSB_T - 14'h0001) begin
        vsb_q <= vsb_sample;
        vok_q <= 1'b1;
      end
    end
  end

  // pin synchronisers; straps mapped bit n-1 for pin n
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pd1_q <= 6'h00;
      pd2_q <= 6'h00;
      pu1_q <= 6'h00;
      pu2_q <= 6'h00;
      dh_q  <= 2'h0;
      dl_q  <= 2'h0;
    end else begin
      pd1_q <= strap_pd_pins;
      pd2_q <= pd1_q;
      pu1_q <= strap_pu_pins;
      pu2_q <= pu1_q;
      dh_q  <= {dh_q[0], led_show_hi};
      dl_q  <= {dl_q[0], led_show_lo};
    end
  end

  // software reset sequence: 00h then 80h
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rreg_q <= RST_ARM;
      swr_q  <= 1'b0;
    end else begin
      swr_q <= hit(addr, A_RST, wr) && (rreg_q == RST_ARM)
               && (write_data == RST_GO);
      if (swr_q) begin
        rreg_q <= RST_ARM;
      end else if (hit(addr, A_RST, wr)) begin
        rreg_q <= write_data;
      end
    end
  end

  // nominal count; write may not exceed learned capacity, but the high byte is taken as written, not clamped
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nac_q <= 16'h0000;
      eff_q <= 4'h0;
    end else if (swr_q) begin
      nac_q <= 16'h0000;
      eff_q <= 4'h0;
    end else begin
      eff_q <= chg_tick ? eff_q + 4'h1 : eff_q;
      if (hit(addr, A_NOMINAL_CHARGE_HIGH, wr)) begin
        nac_q[15:8] <= write_data;
      end else if (chg_cnt && nac_q != 16'hFFFF) begin
        nac_q <= nac_q + 16'h0001;
      end else if ((dsg_tick || sd_en) && nac_q != 16'h0000) begin
        nac_q <= nac_q - 16'h0001;
      end
    end
  end

  // learned capacity, qualified discharge and its counters
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lmd_q  <= PFC_CNT;
      vdq_q  <= 1'b0;
      dacc_q <= 16'h0000;
      self_discharge_counter_q <= 13'h0000;
    end else if (swr_q) begin
      lmd_q  <= PFC_CNT;
      vdq_q  <= 1'b0;
      dacc_q <= 16'h0000;
      self_discharge_counter_q <= 13'h0000;
    end else begin
      if (lmd_upd) begin
        lmd_q <= dacc_q[15:8];
      end else if (hit(addr, A_LMD, wr)) begin
        lmd_q <= write_data;
      end
      // qualify starts on discharge from full, dies on any spoiler
      if (lmd_upd || chg_evt || self_discharge_counter_q >= SELF_DISCHARGE_COUNTER_LIM
          || (e1_hit && !e1_q && temp_code < COLD_TMP)) begin
        vdq_q <= 1'b0;
      end else if (!vdq_q && dsg_tick && nac_q >= {lmd_q, 8'h00}) begin
        vdq_q  <= 1'b1;
        dacc_q <= 16'h0001;
        self_discharge_counter_q <= 13'h0000;
      end else if (vdq_q) begin
        dacc_q <= dacc_q + {15'h0000, dsg_tick};
        if (sd_tick && self_discharge_counter_q < SELF_DISCHARGE_COUNTER_LIM) begin
          self_discharge_counter_q <= self_discharge_counter_q + 13'h0001;
        end
      end
    end
  end

  // charge event counter and stale flag; update clear wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpi_q  <= 8'h00;
      ci_q   <= 1'b1;
      lock_q <= 1'b0;
      vch_q  <= 1'b0;
    end else begin
      vch_q <= valid_charge;
      if (swr_q) begin
        cpi_q  <= 8'h00;
        ci_q   <= 1'b1;
        lock_q <= 1'b0;
      end else if (lmd_upd) begin
        cpi_q <= 8'h00;
        ci_q  <= 1'b0;
      end else begin
        if (cpi_inc) begin
          cpi_q <= cpi_q + 8'h01;
        end
        if (cpi_inc && cpi_q == CPI_STL - 8'h01) begin
          ci_q <= 1'b1;
        end
        if (chg_evt && full94) begin
          lock_q <= 1'b1;
        end else if (below94) begin
          lock_q <= 1'b0;
        end
      end
    end
  end

  // empty flags latch until valid charge; replaced flag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      e1_q  <= 1'b0;
      ef_q  <= 1'b0;
      brp_q <= 1'b1;
    end else begin
      e1_q <= e1_hit || (e1_q && !valid_charge);
      ef_q <= ef_hit || (ef_q && !valid_charge);
      if (swr_q) begin
        brp_q <= 1'b1;
      end else if ((chg_cnt && nac_q + 16'h0001 == {lmd_q, 8'h00})
                   || (chg_evt && e1_q)) begin
        brp_q <= 1'b0;
      end
    end
  end

  // rate code and overload hold-off
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_q <= RATE_LO;
      overload_flag_q <= 1'b0;
      oct_q  <= 14'h0000;
    end else begin
      rate_q <= rate_2c ? RATE_HI : (rate_half ? RATE_MD : RATE_LO);
      if (rate_2c) begin
        overload_flag_q <= 1'b1;
        oct_q  <= 14'h0000;
      end else if (overload_flag_q && tick) begin
        oct_q <= oct_q + 14'h0001;
        if (oct_q == OVERLOAD_FLAG_T - 14'h0001) begin
          overload_flag_q <= 1'b0;
        end
      end
    end
  end

  // compensated capacity and energy, nominal count untouched
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cac_q <= 16'h0000;
      sae_q <= 16'h0000;
    end else begin
      cac_q <= nac_q - (rate_2c ? nac_q >> 3 : 16'h0000)
               - ((temp_code < COLD_TMP) ? nac_q >> 2 : 16'h0000);
      sae_q <= cac_q[15:8] * vsb_q;
    end
  end

  // identifier is never reset: it survives a soft reset
  always_ff @(posedge ref_clk) begin
    if (hit(addr, A_BID, wr)) begin
      bid_q <= write_data;
    end
  end

  // empty threshold setting
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vts_q <= VTS_RST;
    end else if (hit(addr, A_VTS, wr)) begin
      vts_q <= write_data;
    end
  end

  // read mux; unmapped reads return zero
  always_comb begin
    rd_d = 8'h00;
    case (addr)
      A_FLG1: begin
        rd_d[F_CHG] = valid_charge;
        rd_d[F_BRP] = brp_q;
        rd_d[F_CI]  = ci_q;
        rd_d[F_VDQ] = vdq_q;
        rd_d[F_E1]  = e1_q;
        rd_d[F_EF]  = ef_q;
      end
      A_NOMINAL_CHARGE_HIGH: rd_d = nac_q[15:8];
      A_NOMINAL_CHARGE_LOW: rd_d = nac_q[7:0];
      A_BID:  rd_d = bid_q;
      A_LMD:  rd_d = lmd_q;
      A_FLG2: begin
        rd_d[RATE_LSB +: 3] = rate_q;
        rd_d[F_OVERLOAD_FLAG] = overload_flag_q;
      end
      A_PPD:  rd_d = {2'h0, pd2_q};
      A_PPU:  rd_d = {2'h0, pu2_q};
      A_CPI:  rd_d = cpi_q;
      A_VSB:  rd_d = vsb_q;
      A_VTS:  rd_d = vts_q;
      A_COMPENSATED_CHARGE_HIGH: rd_d = cac_q[15:8];
      A_COMPENSATED_CHARGE_LOW: rd_d = cac_q[7:0];
      A_ENERGY_ESTIMATE_HIGH: rd_d = sae_q[15:8];
      A_ENERGY_ESTIMATE_LOW: rd_d = sae_q[7:0];
      default: rd_d = 8'h00;
    endcase
  end

  // read data held until next read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_data <= 8'h00;
      rv_q      <= 1'b0;
    end else begin
      rv_q <= cmd_strobe && !command_byte[7];
      if (cmd_strobe && !command_byte[7]) begin
        read_data <= rd_d;
      end
    end
  end
  assign read_valid = rv_q;

  // display hold machine: low pin starts four seconds
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_show_pin_q <= GM_LED_SHOW_PIN_IDLE;
      sct_q  <= 14'h0000;
      dlp_q  <= 1'b0;
    end else begin
      dlp_q <= dl_q[1];
      case (led_show_pin_q)
        GM_LED_SHOW_PIN_IDLE: begin
          if (dl_q[1] && !dlp_q) begin
            led_show_pin_q <= GM_LED_SHOW_PIN_HOLD;
            sct_q  <= 14'h0000;
          end
        end
        GM_LED_SHOW_PIN_HOLD: begin
          if (tick) begin
            sct_q <= sct_q + 14'h0001;
          end
          if (tick && sct_q == SHOW_T - 14'h0001) begin
            led_show_pin_q <= GM_LED_SHOW_PIN_IDLE;
          end
        end
        default: led_show_pin_q <= GM_LED_SHOW_PIN_IDLE;
      endcase
    end
  end

  // segment k lit when five times capacity exceeds k times learned capacity
  for (genvar k = 0; k < SEG_N; k++) begin : g_seg
    assign lit[k] = ({4'h0, cac_q} * 20'(SEG_N))
                    > (20'(k) * {4'h0, lmd_q, 8'h00});
  end

  assign show = !dh_q[1] && (led_show_pin_q == GM_LED_SHOW_PIN_HOLD
                || (!dl_q[1] && valid_charge));

  // bank multiplex, blink and final-empty blanking
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_q <= 5'h00;
    end else if (!show || ef_q) begin
      led_q <= 5'h00;
    end else begin
      led_q <= lit & ((mux_q < BANK_T) ? BANK_A
               : ((mux_q >= MUX_T / 2 && mux_q < MUX_T / 2 + BANK_T) ? BANK_B
               : 5'h00))
               & ~{4'h0, e1_q && blk_q >= BLINK_T / 2};
    end
  end
  assign led_drive_outputs = led_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_go;
    hit(addr, A_RST, wr) && rreg_q == RST_ARM && write_data == RST_GO;
  endsequence
  sequence s_cleared;
    nac_q == 16'h0000 && lmd_q == PFC_CNT && cpi_q == 8'h00 && ci_q && brp_q;
  endsequence

  property p_reset_go;
    s_go |=> swr_q ##1 s_cleared;
  endproperty
  a_reset_go: assert property (p_reset_go) else $error("soft reset lost");

  property p_cpi_sat;
    (cpi_q == CPI_MAX && !lmd_upd && !swr_q) |=> cpi_q == CPI_MAX;
  endproperty
  a_cpi_sat: assert property (p_cpi_sat) else $error("counter wrapped");

  property p_stale;
    (cpi_inc && cpi_q == CPI_STL - 8'h01 && !lmd_upd && !swr_q) |=> ci_q;
  endproperty
  a_stale: assert property (p_stale) else $error("stale flag missing");

  property p_upd;
    (lmd_upd && !swr_q) |=> cpi_q == 8'h00 && !ci_q && lmd_q == $past(dacc_q[15:8]);
  endproperty
  a_upd: assert property (p_upd) else $error("update effects wrong");

  property p_overload_flag;
    rate_2c |=> overload_flag_q && rate_q == RATE_HI;
  endproperty
  a_overload_flag: assert property (p_overload_flag) else $error("overload not flagged");

  property p_nowsd;
    (sd_tick && pu2_q[STRAP_PIN_FIVE] && !dsg_tick && !chg_cnt && !swr_q && !wr) |=> $stable(nac_q);
  endproperty
  a_nowsd: assert property (p_nowsd) else $error("self-discharge ran");

  property p_banks;
    led_drive_outputs != 5'h00 |-> (led_drive_outputs & BANK_A) == 5'h00
      || (led_drive_outputs & BANK_B) == 5'h00;
  endproperty
  a_banks: assert property (p_banks) else $error("banks overlap");

  property p_final;
    ef_q |=> led_drive_outputs == 5'h00;
  endproperty
  a_final: assert property (p_final) else $error("display on at final empty");

  property p_dhi;
    dh_q[1] |=> led_drive_outputs == 5'h00;
  endproperty
  a_dhi: assert property (p_dhi) else $error("display on with pin high");
endmodule

// file: gm_host_model.sv
/*
  Host side of the command link: sends one command at a time.
  Assumes read_valid follows a taken read by exactly one cycle.
*/
`timescale 1ns/1ps
module gm_host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] read_data,
  input  wire logic       read_valid,
  output logic      [7:0] command_byte,
  output logic            cmd_strobe,
  output logic      [7:0] write_data
);
  initial begin
    command_byte = 8'h00;
    cmd_strobe   = 1'b0;
    write_data   = 8'h00;
  end
  // command held over the taken edge, then released
  task automatic issue(input logic [7:0] cmd, input logic [7:0] wd);
    @(posedge ref_clk);
    command_byte <= cmd;
    write_data   <= wd;
    cmd_strobe   <= 1'b1;
    @(posedge ref_clk);
    cmd_strobe   <= 1'b0;
    write_data   <= ~wd; // stale data must not look valid
  endtask
  // callers keep nominal count within learned capacity, reset byte msb only
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    issue({1'b1, a}, d);
  endtask
  // answer stands during the cycle after the taken edge; look 1 ns after that edge
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    issue({1'b0, a}, 8'h00);
    #1;
    d = read_valid ? read_data : 8'hXX;
  endtask
endmodule

// file: gm_pkg.sv
/*
  Constants for the gauge register map and LED display block.
  Assumes a 20 MHz reference clock.
*/
package gm_pkg;
  // register addresses (low seven command bits)
  localparam logic [6:0] A_FLG1 = 7'h01;
  localparam logic [6:0] A_NOMINAL_CHARGE_HIGH = 7'h03;
  localparam logic [6:0] A_BID  = 7'h04;
  localparam logic [6:0] A_LMD  = 7'h05;
  localparam logic [6:0] A_FLG2 = 7'h06;
  localparam logic [6:0] A_PPD  = 7'h07;
  localparam logic [6:0] A_PPU  = 7'h08;
  localparam logic [6:0] A_CPI  = 7'h09;
  localparam logic [6:0] A_VSB  = 7'h0B;
  localparam logic [6:0] A_VTS  = 7'h0C;
  localparam logic [6:0] A_COMPENSATED_CHARGE_HIGH = 7'h0D;
  localparam logic [6:0] A_COMPENSATED_CHARGE_LOW = 7'h0E;
  localparam logic [6:0] A_ENERGY_ESTIMATE_HIGH = 7'h0F;
  localparam logic [6:0] A_ENERGY_ESTIMATE_LOW = 7'h10;
  localparam logic [6:0] A_NOMINAL_CHARGE_LOW = 7'h17;
  localparam logic [6:0] A_RST  = 7'h39;
  // reset values and codes
  localparam logic [7:0]  VTS_RST  = 8'hA2;
  localparam logic [7:0]  RST_ARM  = 8'h00;
  localparam logic [7:0]  RST_GO   = 8'h80;
  localparam logic [7:0]  PFC_CNT  = 8'h80; // programmed full count
  localparam logic [7:0]  CPI_MAX  = 8'hFF;
  localparam logic [7:0]  CPI_STL  = 8'h40;
  localparam logic [12:0] SELF_DISCHARGE_COUNTER_LIM = 13'h1000;
  localparam logic [3:0]  COLD_TMP = 4'h4;  // first code at 0 C
  localparam logic [3:0]  EFF_LAST = 4'hF;  // one charge tick in 16 lost
  // flag positions
  localparam int RATE_LSB = 4;
  localparam logic [2:0] RATE_LO = 3'h0;
  localparam logic [2:0] RATE_MD = 3'h1;
  localparam logic [2:0] RATE_HI = 3'h2;
  localparam int F_CHG = 7, F_BRP = 6, F_CI = 4, F_VDQ = 3, F_E1 = 1, F_EF = 0;
  localparam int F_OVERLOAD_FLAG = 0;
  localparam int STRAP_PIN_FIVE = 4;
  // 94 percent of learned capacity
  localparam logic [23:0] TH_NUM = 24'h00005E;
  localparam logic [23:0] TH_DEN = 24'h000064;
  // voltage scale: 2400 mV over 256 codes
  localparam int VFS_MV = 2400;
  localparam int VSTEPS = 256;
  localparam int FINAL_EMPTY_FLAG_MV = 50;
  localparam logic [8:0] FINAL_EMPTY_FLAG_CODE = 9'(FINAL_EMPTY_FLAG_MV * VSTEPS / VFS_MV);
  // time base
  localparam int CLK_NS = 50;
  localparam int TICK_US = 500;
  localparam int TICK_CYC = TICK_US * 1000 / CLK_NS;
  localparam int MUX_MS = 10;
  localparam int BANK_PCT = 30;
  localparam int BLINK_MS = 250;
  localparam int OVERLOAD_FLAG_MS = 500;
  localparam int SHOW_MS = 4000;
  localparam int VSB_MS = 1000;
  localparam logic [13:0] MUX_T = 14'(MUX_MS * 1000 / TICK_US);
  localparam logic [13:0] BANK_T = 14'(MUX_MS * 1000 / TICK_US * BANK_PCT / 100);
  localparam logic [13:0] BLINK_T = 14'(BLINK_MS * 1000 / TICK_US);
  localparam logic [13:0] OVERLOAD_FLAG_T = 14'(OVERLOAD_FLAG_MS * 1000 / TICK_US);
  localparam logic [13:0] SHOW_T = 14'(SHOW_MS * 1000 / TICK_US);
  localparam logic [13:0] VSB_T = 14'(VSB_MS * 1000 / TICK_US);
  localparam int SEG_N = 5;
  localparam logic [4:0] BANK_A = 5'h15; // segments 1,3,5
  localparam logic [4:0] BANK_B = 5'h0A; // segments 2,4
  typedef enum {GM_LED_SHOW_PIN_IDLE, GM_LED_SHOW_PIN_HOLD} gm_led_show_pin_t;
endpackage
